// ===== shared/nfc_pkg.sv
// Constants for the host-side controller of a NAND flash sequencer.
// Assumes a 100 MHz system clock and an asynchronous strobe bus to the flash.
package nfc_pkg;
  localparam int CLK_MHZ = 100;
  // Command codes
  localparam logic [7:0] CMD_READ_SETUP = 8'h00;
  localparam logic [7:0] CMD_READ_CONF = 8'h30;
  localparam logic [7:0] CMD_CACHE_READ_CONF = 8'h31;
  localparam logic [7:0] CMD_CACHE_READ_EXIT = 8'h34;
  localparam logic [7:0] CMD_COPY_READ = 8'h35;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
  localparam logic [7:0] CMD_ERASE_CONF = 8'hd0;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_COPY_PROG = 8'h85;
  localparam logic [7:0] CMD_PROG_CONF = 8'h10;
  localparam logic [7:0] CMD_CACHE_PROG_CONF = 8'h15;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_RESET = 8'hff;
  localparam logic [7:0] ID_ADDR = 8'h00;
  localparam logic [7:0] STATUS_AFTER_RESET = 8'he0;
  // Status bit positions
  localparam int SR_PASS_CUR = 0;
  localparam int SR_PASS_PREV = 1;
  localparam int SR_ARRAY_RDY = 5;
  localparam int SR_CACHE_RDY = 6;
  // Address layout (x8): block address starts at bit 6 of the row space
  localparam int ROW_CYCLES = 3;
  localparam int ERASE_CYCLES = 2;
  localparam int COL_CYCLES = 2;
  localparam int ID_BYTES = 4;
  // Strobe timing in ns, converted to cycles (rounded up)
  localparam int T_STROBE_NS = 35;
  localparam int T_HOLD_NS = 20;
  localparam int T_WB_NS = 100;
  localparam int T_STROBE_CYC = (T_STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int T_HOLD_CYC = (T_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int T_WB_CYC = (T_WB_NS * CLK_MHZ + 999) / 1000;
  // Host operations
  typedef enum logic [3:0] {
    NFC_OP_ERASE,
    NFC_OP_COPY_READ,
    NFC_OP_COPY_PROG,
    NFC_OP_CACHE_PROG,
    NFC_OP_STATUS,
    NFC_OP_READ_ID,
    NFC_OP_RESET,
    NFC_OP_CACHE_READ,
    NFC_OP_CACHE_EXIT,
    NFC_OP_READ_RESUME
  } nfc_op_e;
endpackage

// ===== test/nfc_flash_model.sv
// Behavioural flash: command latch, busy timer, status, ID and page output.
// Assumes registered host pins; busy counted in clk cycles; bus floats inverted.
`timescale 1ns/10ps
module nfc_flash_model #(
  parameter int T_BUSY = 40,
  parameter logic [7:0] MAKER = 8'h5a, // Arbitrary value
  parameter logic [7:0] DEVICE = 8'h3c, // Arbitrary value
  parameter logic [7:0] ID_4TH = 8'h15
) (
  input wire logic clk,
  input wire logic cle,
  input wire logic ale,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic [7:0] io_out,
  input wire logic fail_inj,
  output logic [7:0] io_in,
  output logic ready_busy_n
);
  int busy = 0;
  int idx = 0;
  logic rst_busy = 1'b0;
  logic pf = 1'b0;
  logic ppf = 1'b0;
  logic [7:0] mode = 8'h70;
  logic [7:0] dout;
  logic [7:0] last = 8'h00;
  logic [7:0] adr[$];
  logic [7:0] din[$];
  logic [7:0] cmds[$];
  assign ready_busy_n = (busy == 0);
  always @(posedge clk) begin
    if (busy > 0) busy = busy - 1;
    else rst_busy = 1'b0;
  end
  // Busy drops all but status, reset and exit
  always @(posedge write_strobe_n) begin
    if (cle && (busy == 0 || io_out inside {8'h70, 8'hff, 8'h34})) begin
      cmds.push_back(io_out);
      case (io_out)
        8'h70: mode = 8'h70;
        8'h90: begin
          mode = 8'h90;
          idx = 0;
        end
        8'hff: if (!rst_busy) begin
          rst_busy = 1'b1;
          busy = T_BUSY;
          pf = 1'b0;
          ppf = 1'b0;
          mode = 8'h70;
        end
        8'h60, 8'h85, 8'h00: begin
          mode = 8'h00;
          adr.delete();
          din.delete();
        end
        // Confirms start the internal job
        8'hd0, 8'h10, 8'h15, 8'h35, 8'h30, 8'h31: begin
          busy = T_BUSY;
          // Previous page result moves to bit 1 on each program confirm
          if (io_out inside {8'h10, 8'h15}) ppf = pf;
          pf = fail_inj;
          idx = 0;
        end
        8'h34: busy = 4;
        default: ;
      endcase
    end else if (busy == 0 && ale) adr.push_back(io_out);
    else if (busy == 0 && !cle) din.push_back(io_out);
  end
  // Status is live, so a held strobe sees updates
  always_comb begin
    case (mode)
      8'h70: dout = {1'b1, ready_busy_n, ready_busy_n, 3'h0, ppf, pf};
      8'h90: dout = idx == 0 ? MAKER : idx == 1 ? DEVICE : idx == 2 ? 8'h00 : ID_4TH;
      default: dout = 8'ha0 + 8'(idx);
    endcase
  end
  assign io_in = read_strobe_n ? ~last : dout;
  always @(posedge read_strobe_n) begin
    last = dout;
    if (mode != 8'h70) idx++;
  end
endmodule

// ===== test/nfc_host_chk.sv
// Checker on the host's flash pins and user handshake.
// Assumes one clock domain; bound to every nfc_host instance.
`timescale 1ns/10ps
module nfc_host_chk (
  input wire logic clk,
  input wire logic nrst,
  input wire logic op_valid,
  input wire logic op_ready,
  input wire logic done_q,
  input wire logic cle,
  input wire logic ale,
  input wire logic chip_sel_n,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic write_prot_n,
  input wire logic [7:0] io_out,
  input wire logic io_oe,
  input wire logic ready_busy_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  strobe_excl_a: assert property (!(!write_strobe_n && !read_strobe_n))
    else $error("both strobes low");
  latch_excl_a: assert property (!(cle && ale))
    else $error("command and address latch together");
  write_hold_a: assert property ($fell(write_strobe_n) |-> !write_strobe_n ##1
    (!write_strobe_n && $stable(io_out))[*3] ##1 (write_strobe_n && $stable(io_out)))
    else $error("write cycle shape wrong");
  read_pulse_a: assert property ($fell(read_strobe_n) |->
    !read_strobe_n[*4] ##1 read_strobe_n) else $error("read cycle shape wrong");
  drive_write_a: assert property (!write_strobe_n |-> io_oe && !chip_sel_n)
    else $error("bus not driven in write");
  float_read_a: assert property (!read_strobe_n |-> !io_oe)
    else $error("bus driven in read");
  busy_cmd_a: assert property ($fell(write_strobe_n) && cle && !ready_busy_n |->
    io_out inside {8'h70, 8'hff, 8'h34}) else $error("command sent while busy");
  one_op_a: assert property (op_valid && op_ready |=> !op_ready)
    else $error("second op taken at once");
  done_pulse_a: assert property (done_q |=> !done_q)
    else $error("done longer than one cycle");
  wp_high_a: assert property (write_prot_n)
    else $error("write protect asserted");
  cover property ($rose(write_strobe_n) && cle && io_out == 8'hd0);
  cover property ($fell(ready_busy_n));
  cover property (op_valid && op_ready);
endmodule
bind nfc_host nfc_host_chk nfc_host_chk_inst (.clk, .nrst, .op_valid, .op_ready, .done_q,
  .cle, .ale, .chip_sel_n, .write_strobe_n, .read_strobe_n, .write_prot_n, .io_out, .io_oe,
  .ready_busy_n);

// ===== test/nfc_host_tb.sv
// Self-checking bench for nfc_host against the behavioural flash.
// Assumes 100 MHz clock; short busy timeout for simulation.
`timescale 1ns/10ps
module nfc_host_tb;
  import nfc_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic op_valid = 1'b0;
  nfc_op_e op_code = NFC_OP_STATUS;
  logic [23:0] op_row = 24'h0;
  logic [23:0] op_dst_row = 24'h0;
  logic [15:0] op_col = 16'h0;
  logic [11:0] op_len = 12'h0;
  logic op_last = 1'b0;
  logic [7:0] wr_data = 8'h00;
  logic wr_valid = 1'b0;
  logic rd_req = 1'b1;
  logic fail_inj = 1'b0;
  logic op_ready, wr_ready, rd_valid_q, done_q, fail_q, timeout_q, array_busy_q;
  logic cache_read_active_q, cle, ale, chip_sel_n, write_strobe_n, read_strobe_n;
  logic write_prot_n, io_oe, ready_busy_n, rb_low;
  logic [7:0] rd_data_q, status_q, io_out, io_in, b0, b1;
  logic [7:0] rdq[$];
  logic [23:0] row;
  logic [31:0] seed = 32'd87;
  int failures = 0;
  int n_tests = 0;
  nfc_host #(.BUSY_TIMEOUT(2000)) nfc_host_inst (.clk, .nrst, .op_valid, .op_ready, .op_code,
    .op_row, .op_dst_row, .op_col, .op_len, .op_last, .wr_data, .wr_valid, .wr_ready,
    .rd_data_q, .rd_valid_q, .rd_req, .status_q, .done_q, .fail_q, .timeout_q, .array_busy_q,
    .cache_read_active_q, .cle, .ale, .chip_sel_n, .write_strobe_n, .read_strobe_n,
    .write_prot_n, .io_out, .io_oe, .io_in, .ready_busy_n);
  nfc_flash_model m (.clk, .cle, .ale, .write_strobe_n, .read_strobe_n, .io_out, .fail_inj,
    .io_in, .ready_busy_n);
  always #5 clk = ~clk;
  always @(posedge clk) begin
    if (rd_valid_q === 1'b1) rdq.push_back(rd_data_q);
    if (ready_busy_n === 1'b0) rb_low = 1'b1;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] has(input logic [7:0] c);
    foreach (m.cmds[i]) if (m.cmds[i] === c) return 8'h01;
    return 8'h00;
  endfunction
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic push(input logic [7:0] b);
    @(posedge clk);
    wr_data <= b;
    wr_valid <= 1'b1;
    do @(posedge clk); while (wr_ready !== 1'b1);
    wr_valid <= 1'b0;
  endtask
  // Hold the request until taken, then wait a bounded time for done
  task automatic run(input nfc_op_e c, input logic [11:0] len, input logic lst);
    int n;
    n = 0;
    m.cmds.delete();
    rdq.delete();
    @(posedge clk);
    op_code <= c;
    op_row <= row;
    op_dst_row <= row + 24'h40;
    op_len <= len;
    op_last <= lst;
    op_valid <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (op_ready !== 1'b1 && n < 9000);
    op_valid <= 1'b0;
    while (done_q !== 1'b1 && n < 9000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 9000) failures++;
    $display("test %s ended", c.name());
  endtask
  task automatic conclude();
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    conclude();
  end
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    row = 24'(rnd());
    run(NFC_OP_ERASE, 12'h0, 1'b0);
    chk("erase setup", 8'h60, m.cmds[0]);
    chk("erase confirm", 8'hd0, m.cmds[1]);
    chk("block low", {row[7:6], 6'h00}, m.adr[0]);
    chk("block high", row[15:8], m.adr[1]);
    chk("erase status", 8'he0, status_q);
    chk("erase timeout", 8'h00, {7'h00, timeout_q});
    fail_inj <= 1'b1;
    run(NFC_OP_ERASE, 12'h0, 1'b0);
    chk("erase fail", 8'h01, {7'h00, fail_q});
    fail_inj <= 1'b0;
    rb_low = 1'b0;
    run(NFC_OP_RESET, 12'h0, 1'b0);
    chk("reset cmd", 8'h01, has(8'hff));
    chk("reset busy", 8'h01, {7'h00, rb_low});
    run(NFC_OP_STATUS, 12'h0, 1'b0);
    chk("reset status", 8'he0, status_q);
    chk("status", 8'h01, has(8'h70));
    run(NFC_OP_READ_RESUME, 12'h0, 1'b0);
    chk("resume", 8'h01, has(8'h00));
    run(NFC_OP_READ_ID, 12'h4, 1'b0);
    chk("id addr", 8'h00, m.adr[0]);
    chk("id 0", 8'h5a, rdq[0]);
    chk("id 1", 8'h3c, rdq[1]);
    chk("id 2", 8'h00, rdq[2]);
    chk("id 3", 8'h15, rdq[3]);
    run(NFC_OP_COPY_READ, 12'h0, 1'b0);
    chk("copy load", 8'h01, has(8'h35));
    b0 = 8'(rnd());
    b1 = 8'(rnd());
    push(b0);
    push(b1);
    run(NFC_OP_COPY_PROG, 12'h2, 1'b0);
    chk("copy dest", 8'h01, has(8'h85) & has(8'h10));
    chk("copy data 0", b0, m.din[0]);
    chk("copy data 1", b1, m.din[1]);
    push(b1);
    run(NFC_OP_CACHE_PROG, 12'h1, 1'b0);
    chk("cache confirm", 8'h01, has(8'h15));
    chk("array free", 8'h00, {7'h00, array_busy_q});
    push(b0);
    run(NFC_OP_CACHE_PROG, 12'h1, 1'b1);
    chk("cache last", 8'h01, has(8'h10));
    run(NFC_OP_CACHE_READ, 12'h3, 1'b0);
    chk("cache read", 8'h01, has(8'h31));
    chk("cache active", 8'h01, {7'h00, cache_read_active_q});
    chk("col low", 8'h00, m.adr[0]);
    for (int i = 0; i < 3; i++) chk("cache byte", 8'ha0 + 8'(i), rdq[i]);
    run(NFC_OP_CACHE_EXIT, 12'h0, 1'b0);
    chk("cache exit", 8'h01, has(8'h34));
    chk("cache idle", 8'h00, {7'h00, cache_read_active_q});
    conclude();
  end
endmodule

// ===== verilog/nfc_fifo.sv
// Synchronous FIFO for write data on its way to the flash.
// Assumes one clock; full and empty are exact.
`timescale 1ns/10ps
module nfc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = cnt_q != (AW+1)'(DEPTH);
  assign out_valid = cnt_q != '0;
  assign out_data = mem[rd_q];
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ===== verilog/nfc_host.sv
// Host-side sequencer for erase, copy-back, cache program/read, status, ID, reset.
// Assumes a flash on the strobe pins; ready_busy_n is the pulled-up open-drain line.
// Overview of operation
// - Erase is 60h, two block cycles, D0h
// - 85h, destination, optional data, then 10h
// - Issue 00h before resuming array reads
// - ID is 90h, 00h, four reads
// - Cache program stays inside one block; op_row is not checked against the block of the run
// - Last cached page uses 10h or poll
// - Cache read confirmed with 31h, column zero
// - No random column out; exit at end
`timescale 1ns/10ps
module nfc_host #(
  parameter int FIFO_DEPTH = 8,
  parameter int BUSY_TIMEOUT = 32'd1000000
) (
  input wire logic clk,
  input wire logic nrst,
  // User side
  input wire logic op_valid,
  output logic op_ready,
  input wire nfc_pkg::nfc_op_e op_code,
  input wire logic [23:0] op_row,
  input wire logic [23:0] op_dst_row,
  input wire logic [15:0] op_col,
  input wire logic [11:0] op_len,
  input wire logic op_last,
  input wire logic [7:0] wr_data,
  input wire logic wr_valid,
  output logic wr_ready,
  output logic [7:0] rd_data_q,
  output logic rd_valid_q,
  input wire logic rd_req,
  output logic [7:0] status_q,
  output logic done_q,
  output logic fail_q,
  output logic timeout_q,
  output logic array_busy_q,
  output logic cache_read_active_q,
  // Flash pins
  output logic cle,
  output logic ale,
  output logic chip_sel_n,
  output logic write_strobe_n,
  output logic read_strobe_n,
  output logic write_prot_n,
  output logic [7:0] io_out,
  output logic io_oe,
  input wire logic [7:0] io_in,
  input wire logic ready_busy_n
);
  import nfc_pkg::*;
  typedef enum {
    NFC_IDLE, NFC_CMD1, NFC_ADDR, NFC_DATA, NFC_CMD2, NFC_WB, NFC_WAIT,
    NFC_STAT_CMD, NFC_STAT_RD, NFC_RD, NFC_FIN
  } nfc_state_e;
  nfc_state_e st_q;
  nfc_op_e op_q;
  logic [23:0] row_q;
  logic [15:0] col_q;
  logic [11:0] len_q;
  logic [2:0] acnt_q;
  logic [2:0] alen_q;
  logic [7:0] cmd2_q;
  logic has_cmd2_q;
  logic last_q;
  logic [31:0] tcnt_q;
  logic [7:0] sb_wdata;
  logic [1:0] sb_kind;
  logic sb_req;
  logic sb_done;
  logic [7:0] sb_rdata;
  logic [7:0] f_data;
  logic f_valid;
  logic f_ready;
  // Byte of the address stream: column first, then row
  logic [47:0] addr_bytes;
  assign addr_bytes = {8'h00, row_q, col_q};
  // Erase starts at the first row byte so the block bits land where the flash expects them
  wire [2:0] abase = (op_q == NFC_OP_ERASE) ? 3'd2 : 3'd0;
  wire [7:0] addr_byte = addr_bytes[8*(abase + acnt_q) +: 8];
  nfc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .nrst(nrst),
    .in_data(wr_data),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .out_data(f_data),
    .out_valid(f_valid),
    .out_ready(f_ready)
  );
  nfc_strobe u_sb (
    .clk(clk),
    .nrst(nrst),
    .req(sb_req),
    .kind(sb_kind),
    .wdata(sb_wdata),
    .done(sb_done),
    .rdata_q(sb_rdata),
    .cle_q(cle),
    .ale_q(ale),
    .write_strobe_n_q(write_strobe_n),
    .read_strobe_n_q(read_strobe_n),
    .io_out_q(io_out),
    .io_oe_q(io_oe),
    .io_in(io_in)
  );
  // First command of each operation
  logic [7:0] cmd1;
  always_comb begin
    case (op_q)
      NFC_OP_ERASE: cmd1 = CMD_ERASE_SETUP;
      NFC_OP_COPY_READ: cmd1 = CMD_READ_SETUP;
      NFC_OP_COPY_PROG: cmd1 = CMD_COPY_PROG;
      NFC_OP_CACHE_PROG: cmd1 = CMD_COPY_PROG;
      NFC_OP_STATUS: cmd1 = CMD_STATUS;
      NFC_OP_READ_ID: cmd1 = CMD_READ_ID;
      NFC_OP_RESET: cmd1 = CMD_RESET;
      NFC_OP_CACHE_READ: cmd1 = CMD_READ_SETUP;
      NFC_OP_CACHE_EXIT: cmd1 = CMD_CACHE_READ_EXIT;
      NFC_OP_READ_RESUME: cmd1 = CMD_READ_SETUP;
      default: cmd1 = CMD_STATUS;
    endcase
  end
  // Busy flash accepts only status, reset and, during a cache read, exit; other orders wait for ready
  wire flash_busy = !ready_busy_n || array_busy_q;
  wire op_allowed = !flash_busy || op_code == NFC_OP_STATUS || op_code == NFC_OP_RESET
    || (op_code == NFC_OP_CACHE_EXIT && cache_read_active_q);
  wire resetting = (op_q == NFC_OP_RESET) && (st_q != NFC_IDLE);
  // Reset order is refused while a reset is still running
  wire reset_block = op_code == NFC_OP_RESET && resetting;
  assign op_ready = (st_q == NFC_IDLE) && op_allowed && !reset_block;
  assign chip_sel_n = 1'b0;
  assign write_prot_n = 1'b1;
  wire timed_out = tcnt_q == 32'(BUSY_TIMEOUT);
  always_comb begin
    sb_req = 1'b0;
    sb_kind = 2'd0;
    sb_wdata = cmd1;
    f_ready = 1'b0;
    case (st_q)
      NFC_CMD1: begin
        sb_req = 1'b1;
      end
      NFC_ADDR: begin
        sb_req = 1'b1;
        sb_kind = 2'd1;
        sb_wdata = addr_byte;
      end
      NFC_DATA: begin
        sb_req = f_valid;
        sb_kind = 2'd2;
        sb_wdata = f_data;
        f_ready = sb_done;
      end
      NFC_CMD2: begin
        sb_req = 1'b1;
        sb_wdata = cmd2_q;
      end
      NFC_STAT_CMD: begin
        sb_req = 1'b1;
        sb_wdata = CMD_STATUS;
      end
      NFC_STAT_RD: begin
        sb_req = 1'b1;
        sb_kind = 2'd3;
      end
      NFC_RD: begin
        sb_req = rd_req && !rd_valid_q;
        sb_kind = 2'd3;
      end
      default: sb_req = 1'b0;
    endcase
  end
  // Per-operation setup
  logic [2:0] alen_d;
  logic [7:0] cmd2_d;
  logic has2_d;
  always_comb begin
    alen_d = 3'd0;
    cmd2_d = CMD_PROG_CONF;
    has2_d = 1'b0;
    case (op_code)
      NFC_OP_ERASE: begin
        alen_d = 3'(ERASE_CYCLES);
        cmd2_d = CMD_ERASE_CONF;
        has2_d = 1'b1;
      end
      NFC_OP_COPY_READ: begin
        alen_d = 3'(COL_CYCLES + ROW_CYCLES);
        cmd2_d = CMD_COPY_READ;
        has2_d = 1'b1;
      end
      NFC_OP_COPY_PROG, NFC_OP_CACHE_PROG: begin
        alen_d = 3'(COL_CYCLES + ROW_CYCLES);
        // Last page of a cached run goes out with 10h so busy tracking is sound
        cmd2_d = (op_code == NFC_OP_CACHE_PROG && !op_last) ?
          CMD_CACHE_PROG_CONF : CMD_PROG_CONF;
        has2_d = 1'b1;
      end
      NFC_OP_READ_ID: alen_d = 3'd1;
      NFC_OP_CACHE_READ: begin
        alen_d = 3'(COL_CYCLES + ROW_CYCLES);
        cmd2_d = CMD_CACHE_READ_CONF;
        has2_d = 1'b1;
      end
      default: alen_d = 3'd0;
    endcase
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= NFC_IDLE;
      op_q <= NFC_OP_STATUS;
      row_q <= '0;
      col_q <= '0;
      len_q <= '0;
      acnt_q <= '0;
      alen_q <= '0;
      cmd2_q <= '0;
      has_cmd2_q <= 1'b0;
      last_q <= 1'b0;
      tcnt_q <= '0;
      rd_data_q <= '0;
      rd_valid_q <= 1'b0;
      status_q <= '0;
      done_q <= 1'b0;
      fail_q <= 1'b0;
      timeout_q <= 1'b0;
      array_busy_q <= 1'b0;
      cache_read_active_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      rd_valid_q <= 1'b0;
      case (st_q)
        NFC_IDLE: begin
          if (op_valid && op_ready) begin
            op_q <= op_code;
            // Erase uses the block field only; page bits forced to zero
            row_q <= (op_code == NFC_OP_ERASE) ? {op_row[23:6], 6'h00} :
              (op_code == NFC_OP_COPY_PROG ? op_dst_row : op_row);
            // Cache read always begins at column zero; ID address is 00h
            col_q <= (op_code == NFC_OP_CACHE_READ) ? 16'h0000 :
              (op_code == NFC_OP_READ_ID ? {8'h00, ID_ADDR} : op_col);
            len_q <= (op_code == NFC_OP_READ_ID) ? 12'(ID_BYTES) : op_len;
            alen_q <= alen_d;
            cmd2_q <= cmd2_d;
            has_cmd2_q <= has2_d;
            last_q <= op_last;
            acnt_q <= '0;
            timeout_q <= 1'b0;
            st_q <= NFC_CMD1;
          end
        end
        NFC_CMD1: if (sb_done) begin
          if (op_q == NFC_OP_CACHE_EXIT) begin
            cache_read_active_q <= 1'b0;
            st_q <= NFC_WB;
          end else if (op_q == NFC_OP_RESET) begin
            array_busy_q <= 1'b0;
            cache_read_active_q <= 1'b0;
            st_q <= NFC_WB;
          end else if (op_q == NFC_OP_STATUS) begin
            st_q <= NFC_STAT_RD;
          end else if (op_q == NFC_OP_READ_RESUME) begin
            st_q <= NFC_FIN;
          end else begin
            st_q <= (alen_q != 3'd0) ? NFC_ADDR : NFC_FIN;
          end
        end
        NFC_ADDR: if (sb_done) begin
          acnt_q <= acnt_q + 3'd1;
          if (acnt_q == alen_q - 3'd1) begin
            if (op_q == NFC_OP_READ_ID) begin
              st_q <= NFC_RD;
            end else if ((op_q == NFC_OP_COPY_PROG || op_q == NFC_OP_CACHE_PROG)
                && len_q != '0) begin
              st_q <= NFC_DATA;
            end else begin
              st_q <= NFC_CMD2;
            end
          end
        end
        NFC_DATA: if (sb_done) begin
          len_q <= len_q - 12'd1;
          if (len_q == 12'd1) begin
            st_q <= NFC_CMD2;
          end
        end
        NFC_CMD2: if (sb_done) begin
          // Write strobe rise of confirm starts the internal operation
          st_q <= NFC_WB;
          if (op_q == NFC_OP_CACHE_PROG && !last_q) begin
            array_busy_q <= 1'b1;
          end
          if (op_q == NFC_OP_CACHE_READ) begin
            cache_read_active_q <= 1'b1;
          end
        end
        NFC_WB: begin
          // Ready/busy is not valid until the flash has had time to drop it
          tcnt_q <= tcnt_q + 32'd1;
          if (tcnt_q == 32'(T_WB_CYC)) begin
            tcnt_q <= '0;
            st_q <= NFC_WAIT;
          end
        end
        NFC_WAIT: begin
          tcnt_q <= tcnt_q + 32'd1;
          if (ready_busy_n) begin
            tcnt_q <= '0;
            // Erase and program results need the status byte
            st_q <= (op_q == NFC_OP_ERASE || op_q == NFC_OP_COPY_PROG
              || op_q == NFC_OP_CACHE_PROG) ? NFC_STAT_CMD :
              (op_q == NFC_OP_CACHE_READ ? NFC_RD : NFC_FIN);
          end else if (timed_out) begin
            timeout_q <= 1'b1;
            tcnt_q <= '0;
            st_q <= NFC_FIN;
          end
        end
        NFC_STAT_CMD: if (sb_done) begin
          st_q <= NFC_STAT_RD;
        end
        NFC_STAT_RD: if (sb_done) begin
          status_q <= sb_rdata;
          // Array ready bit tells when a cached program truly finished
          if (sb_rdata[SR_ARRAY_RDY]) begin
            array_busy_q <= 1'b0;
          end
          if (op_q == NFC_OP_CACHE_PROG && !last_q) begin
            fail_q <= sb_rdata[SR_PASS_PREV];
          end else if (op_q != NFC_OP_STATUS) begin
            fail_q <= sb_rdata[SR_PASS_CUR] | sb_rdata[SR_PASS_PREV];
          end
          st_q <= NFC_FIN;
        end
        NFC_RD: begin
          if (sb_done) begin
            rd_data_q <= sb_rdata;
            rd_valid_q <= 1'b1;
            len_q <= len_q - 12'd1;
            if (len_q == 12'd1) begin
              st_q <= NFC_FIN;
            end
          end
        end
        NFC_FIN: begin
          done_q <= 1'b1;
          st_q <= NFC_IDLE;
        end
        default: st_q <= NFC_IDLE;
      endcase
    end
  end
endmodule

// ===== verilog/nfc_strobe.sv
// Bus cycle engine: one command, address, data-in or data-out cycle per request.
// Assumes flash inputs are synchronous to clk; strobe widths come from the package.
`timescale 1ns/10ps
module nfc_strobe (
  input wire logic clk,
  input wire logic nrst,
  input wire logic req,
  input wire logic [1:0] kind,
  input wire logic [7:0] wdata,
  output logic done,
  output logic [7:0] rdata_q,
  output logic cle_q,
  output logic ale_q,
  output logic write_strobe_n_q,
  output logic read_strobe_n_q,
  output logic [7:0] io_out_q,
  output logic io_oe_q,
  input wire logic [7:0] io_in
);
  import nfc_pkg::*;
  // Kind: 0 command, 1 address, 2 data write, 3 data read
  typedef enum {NFC_SB_IDLE, NFC_SB_LOW, NFC_SB_HIGH} nfc_sb_e;
  nfc_sb_e st_q;
  logic [7:0] cnt_q;
  wire is_read = kind == 2'd3;
  wire low_end = cnt_q == 8'(T_STROBE_CYC - 1);
  wire high_end = cnt_q == 8'(T_HOLD_CYC - 1);
  assign done = (st_q == NFC_SB_HIGH) && high_end;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= NFC_SB_IDLE;
      cnt_q <= '0;
      cle_q <= 1'b0;
      ale_q <= 1'b0;
      write_strobe_n_q <= 1'b1;
      read_strobe_n_q <= 1'b1;
      io_out_q <= '0;
      io_oe_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      case (st_q)
        NFC_SB_IDLE: begin
          cnt_q <= '0;
          if (req) begin
            st_q <= NFC_SB_LOW;
            cle_q <= kind == 2'd0;
            ale_q <= kind == 2'd1;
            io_out_q <= wdata;
            io_oe_q <= !is_read;
            write_strobe_n_q <= is_read;
            read_strobe_n_q <= !is_read;
          end
        end
        NFC_SB_LOW: begin
          cnt_q <= cnt_q + 8'h01;
          if (low_end) begin
            // Sample read data just before the rising read strobe
            if (!read_strobe_n_q) begin
              rdata_q <= io_in;
            end
            write_strobe_n_q <= 1'b1;
            read_strobe_n_q <= 1'b1;
            cnt_q <= '0;
            st_q <= NFC_SB_HIGH;
          end
        end
        NFC_SB_HIGH: begin
          cnt_q <= cnt_q + 8'h01;
          if (high_end) begin
            cle_q <= 1'b0;
            ale_q <= 1'b0;
            io_oe_q <= 1'b0;
            st_q <= NFC_SB_IDLE;
          end
        end
        default: st_q <= NFC_SB_IDLE;
      endcase
    end
  end
endmodule
